// ==== shared/tmc_pkg.sv ====
// Constants for the timer channel mode control block
package tmc_pkg;
  // =====================================================
  // Register map (byte addresses)
  localparam int AW = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CV0 = 8'h04;
  localparam logic [7:0] ADDR_CV1 = 8'h08;
  localparam logic [7:0] ADDR_ADD0 = 8'h0c;
  localparam logic [7:0] ADDR_ADD1 = 8'h10;
  localparam logic [7:0] ADDR_CHCTL = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1c;
  localparam logic [7:0] ADDR_CAP0 = 8'h20;
  localparam logic [7:0] ADDR_CAP1 = 8'h24;
  localparam logic [31:0] CHCTL_RST = 32'h0000_0000;
  localparam logic [31:0] CHCTL_WMASK = 32'hdf01_ffff;
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [5:0] CFG_WMASK = 6'h3f;
  localparam logic [15:0] VAL_RST = 16'h0000;
  // =====================================================
  // Field positions in the channel control word
  localparam int CH_STRIDE = 8;
  localparam int MS_LO = 0;
  localparam int MS_TOP = 30;
  localparam int FAST_BIT = 2;
  localparam int SHD_BIT = 3;
  localparam int CTL_LO = 4;
  localparam int CTL_TOP = 16;
  localparam int CLR_BIT = 7;
  localparam int PSC_LO = 2;
  localparam int FLT_LO = 4;
  // Own configuration word: enable, composite, polarity
  localparam int CFG_EN = 0;
  localparam int CFG_CPWM = 2;
  localparam int CFG_POL = 4;
  // =====================================================
  // Encodings
  localparam logic [2:0] IO_OUT = 3'h0;
  localparam logic [2:0] IO_OWN = 3'h1;
  localparam logic [2:0] IO_OTHER = 3'h2;
  localparam logic [2:0] IO_ITS = 3'h3;
  localparam logic [3:0] CC_TIMING = 4'h0;
  localparam logic [3:0] CC_SET = 4'h1;
  localparam logic [3:0] CC_CLR = 4'h2;
  localparam logic [3:0] CC_TOG = 4'h3;
  localparam logic [3:0] CC_LOW = 4'h4;
  localparam logic [3:0] CC_HIGH = 4'h5;
  localparam logic [3:0] CC_PWM0 = 4'h6;
  localparam logic [3:0] CC_PWM1 = 4'h7;
  localparam logic [3:0] CC_SPM0 = 4'h8;
  localparam logic [3:0] CC_SPM1 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // =====================================================
  // Timing in clock cycles, trigger edge to output pin
  localparam int FAST_DLY = 3;
  localparam int SLOW_DLY = 5;
  localparam int TRIG_PIPE = SLOW_DLY - FAST_DLY;
endpackage

// ==== src/tmc_timer_channel_mode_control.sv ====
// Timer channel 0/1 mode control with AXI4-Lite register slave
`timescale 1ns/1ps
module tmc_timer_channel_mode_control
  import tmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] counter_value_i,
  input wire logic count_down_i,
  input wire logic update_evt_i,
  input wire logic trig_edge_i,
  input wire logic internal_trigger_i,
  input wire logic ext_trigger_filtered_i,
  input wire logic chan0_in_i,
  input wire logic chan1_in_i,
  output logic chan0_reference_out_o,
  output logic chan1_reference_out_o,
  output logic chan0_output_pin_o,
  output logic chan1_output_pin_o,
  output logic chan0_capture_o,
  output logic chan1_capture_o
);
  // =====================================================
  // State
  typedef struct packed {
    logic aw_ok;
    logic [AW-1:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] cfg;
    logic [31:0] chctl;
    logic [1:0][15:0] cv_pre;
    logic [1:0][15:0] cv_act;
    logic [1:0][15:0] add;
    logic [1:0][15:0] cap;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] filt;
    logic [1:0][3:0] fcnt;
    logic [4:0] divcnt;
    logic [1:0] src_prev;
    logic [1:0][2:0] psc;
    logic [1:0] cap_p;
    logic trig_q;
    logic [TRIG_PIPE-1:0] trig_pipe;
    logic [1:0] fired;
    logic [1:0] ref_lvl;
    logic [1:0] pin;
  } tmc_state_t;

  tmc_state_t s_q;
  tmc_state_t s_d;

  // =====================================================
  // Helpers
  function automatic logic reg_hit(input logic [AW-1:0] a);
    case (a)
      ADDR_CFG, ADDR_CV0, ADDR_CV1, ADDR_ADD0, ADDR_ADD1,
      ADDR_CHCTL, ADDR_STAT, ADDR_CAP0, ADDR_CAP1: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [3:0] strb);
    wmerge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        wmerge[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
  endfunction

  // Samples needed before the filtered level flips
  function automatic logic [3:0] flt_n(input logic [3:0] c);
    case (c)
      4'h0: flt_n = 4'h1;
      4'h1: flt_n = 4'h2;
      4'h2: flt_n = 4'h4;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: flt_n = 4'h8;
      4'ha, 4'hd: flt_n = 4'h5;
      default: flt_n = 4'h6;
    endcase
  endfunction

  // Log2 of the input filter sampling clock divider; 0 samples every cycle
  function automatic logic [2:0] flt_div(input logic [3:0] c);
    case (c)
      4'h4, 4'h5: flt_div = 3'h1;
      4'h6, 4'h7: flt_div = 3'h2;
      4'h8, 4'h9: flt_div = 3'h3;
      4'ha, 4'hb, 4'hc: flt_div = 3'h4;
      4'hd, 4'he, 4'hf: flt_div = 3'h5;
      default: flt_div = 3'h0;
    endcase
  endfunction

  // =====================================================
  // Next state
  always_comb begin
    logic [2:0] io;
    logic [3:0] cc;
    logic [3:0] fc;
    logic [2:0] dv;
    logic [1:0] ps;
    logic [5:0] smp_en;
    logic en;
    logic up;
    logic src;
    logic p_up;
    logic p_dn;
    logic pwm0;
    logic pwm1;
    logic trig_slow;
    logic [2:0] psc_top;
    logic [31:0] wv;
    logic [1:0] wi;
    s_d = s_q;
    io = 3'h0;
    cc = 4'h0;
    fc = 4'h0;
    dv = 3'h0;
    ps = 2'h0;
    en = 1'b0;
    src = 1'b0;
    p_up = 1'b0;
    p_dn = 1'b0;
    pwm0 = 1'b0;
    pwm1 = 1'b0;
    psc_top = 3'h0;
    wv = 32'h0;
    wi = 2'h0;
    up = ~count_down_i;
    smp_en = 6'h01;
    for (int k = 1; k < 6; k++) begin
      smp_en[k] = smp_en[k-1] & s_q.divcnt[k-1];
    end
    s_d.divcnt = s_q.divcnt + 5'h01;
    s_d.sync1 = {chan1_in_i, chan0_in_i};
    s_d.sync2 = s_q.sync1;
    s_d.trig_q = trig_edge_i;
    // Slow trigger path adds stages so the pin follows in 5 cycles
    s_d.trig_pipe = {s_q.trig_pipe[TRIG_PIPE-2:0], s_q.trig_q};
    trig_slow = s_q.trig_pipe[TRIG_PIPE-1];
    s_d.cap_p = 2'b00;

    for (int i = 0; i < 2; i++) begin
      io = {s_q.chctl[MS_TOP+i], s_q.chctl[MS_LO+CH_STRIDE*i +: 2]};
      cc = {s_q.chctl[CTL_TOP+CH_STRIDE*i], s_q.chctl[CTL_LO+CH_STRIDE*i +: 3]};
      fc = s_q.chctl[FLT_LO+CH_STRIDE*i +: 4];
      ps = s_q.chctl[PSC_LO+CH_STRIDE*i +: 2];
      en = s_q.cfg[CFG_EN+i];

      // digital filter on the synchronised input
      dv = flt_div(fc);
      if (smp_en[dv]) begin
        if (s_q.sync2[i] == s_q.filt[i]) begin
          s_d.fcnt[i] = 4'h0;
        end else if (s_q.fcnt[i] + 4'h1 >= flt_n(fc)) begin
          s_d.filt[i] = s_q.sync2[i];
          s_d.fcnt[i] = 4'h0;
        end else begin
          s_d.fcnt[i] = s_q.fcnt[i] + 4'h1;
        end
      end

      case (io)
        IO_OWN: src = s_q.filt[i];
        IO_OTHER: src = s_q.filt[1-i];
        IO_ITS: src = internal_trigger_i;
        default: src = 1'b0;
      endcase
      s_d.src_prev[i] = src;

      psc_top = 3'((4'h1 << ps) - 4'h1);
      if (!en) begin
        s_d.psc[i] = 3'h0;
      end else if ((io == IO_OWN || io == IO_OTHER || io == IO_ITS)
                   && src && !s_q.src_prev[i]) begin
        if (s_q.psc[i] >= psc_top) begin
          s_d.psc[i] = 3'h0;
          s_d.cap[i] = counter_value_i;
          s_d.cap_p[i] = 1'b1;
        end else begin
          s_d.psc[i] = s_q.psc[i] + 3'h1;
        end
      end

      // shadowed compare value loads at update
      if (update_evt_i && s_q.chctl[SHD_BIT+CH_STRIDE*i]) begin
        s_d.cv_act[i] = s_q.cv_pre[i];
      end

      if (trig_slow) begin
        s_d.fired[i] = 1'b1;
      end else if (update_evt_i) begin
        s_d.fired[i] = 1'b0;
      end

      p_up = counter_value_i >= s_q.cv_act[i];
      p_dn = counter_value_i > s_q.cv_act[i];
      if (s_q.cfg[CFG_CPWM+i] && io == IO_OUT) begin
        p_up = p_up ^ (counter_value_i >= s_q.add[i]);
        p_dn = p_dn ^ (counter_value_i > s_q.add[i]);
      end
      pwm0 = up ? ~p_up : ~p_dn;
      pwm1 = ~pwm0;

      if (io == IO_OUT) begin
        case (cc)
          CC_SET: if (counter_value_i == s_q.cv_act[i]) s_d.ref_lvl[i] = 1'b1;
          CC_CLR: if (counter_value_i == s_q.cv_act[i]) s_d.ref_lvl[i] = 1'b0;
          CC_TOG: if (counter_value_i == s_q.cv_act[i]) s_d.ref_lvl[i] = ~s_q.ref_lvl[i];
          CC_LOW: s_d.ref_lvl[i] = 1'b0;
          CC_HIGH: s_d.ref_lvl[i] = 1'b1;
          // level follows the compare result; fast trigger and clear below can override it
          CC_PWM0: s_d.ref_lvl[i] = pwm0;
          CC_PWM1: s_d.ref_lvl[i] = pwm1;
          CC_SPM0: s_d.ref_lvl[i] = up ? ~s_d.fired[i] : s_d.fired[i];
          CC_SPM1: s_d.ref_lvl[i] = up ? s_d.fired[i] : ~s_d.fired[i];
          default: s_d.ref_lvl[i] = s_q.ref_lvl[i];
        endcase
        // fast trigger acts as a compare match
        if (s_q.chctl[FAST_BIT+CH_STRIDE*i] && s_q.trig_q
            && (cc == CC_PWM0 || cc == CC_PWM1)) begin
          s_d.ref_lvl[i] = (cc == CC_PWM1) ? up : ~up;
        end
        if (s_q.chctl[CLR_BIT+CH_STRIDE*i] && ext_trigger_filtered_i) begin
          s_d.ref_lvl[i] = 1'b0;
        end
      end
      s_d.pin[i] = s_q.ref_lvl[i] ^ s_q.cfg[CFG_POL+i];
    end

    // =====================================================
    // AXI4-Lite write channel
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_ok = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_ok = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
      s_d.aw_ok = 1'b0;
      s_d.w_ok = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = reg_hit(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_q.awaddr)
        ADDR_CFG: begin
          wv = wmerge({26'h0, s_q.cfg}, s_q.wdata, s_q.wstrb);
          s_d.cfg = wv[5:0] & CFG_WMASK;
        end
        ADDR_CV0, ADDR_CV1: begin
          wi = (s_q.awaddr == ADDR_CV1) ? 2'h1 : 2'h0;
          wv = wmerge({16'h0, s_q.cv_pre[wi[0]]}, s_q.wdata, s_q.wstrb);
          s_d.cv_pre[wi[0]] = wv[15:0];
          // without shadow the write takes effect at once
          if (!s_q.chctl[SHD_BIT+CH_STRIDE*wi[0]]) begin
            s_d.cv_act[wi[0]] = wv[15:0];
          end
        end
        ADDR_ADD0, ADDR_ADD1: begin
          wi = (s_q.awaddr == ADDR_ADD1) ? 2'h1 : 2'h0;
          wv = wmerge({16'h0, s_q.add[wi[0]]}, s_q.wdata, s_q.wstrb);
          s_d.add[wi[0]] = wv[15:0];
        end
        ADDR_CHCTL: begin
          wv = wmerge(s_q.chctl, s_q.wdata, s_q.wstrb) & CHCTL_WMASK;
          // mode field locked while channel enabled
          for (int i = 0; i < 2; i++) begin
            if (s_q.cfg[CFG_EN+i]) begin
              wv[MS_TOP+i] = s_q.chctl[MS_TOP+i];
              wv[MS_LO+CH_STRIDE*i +: 2] = s_q.chctl[MS_LO+CH_STRIDE*i +: 2];
            end
          end
          s_d.chctl = wv;
        end
        default: ;
      endcase
    end
    s_d.awready = !s_d.aw_ok && !s_d.bvalid;
    s_d.wready = !s_d.w_ok && !s_d.bvalid;

    // =====================================================
    // AXI4-Lite read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        ADDR_CFG: s_d.rdata = {26'h0, s_q.cfg};
        ADDR_CV0: s_d.rdata = {16'h0, s_q.cv_pre[0]};
        ADDR_CV1: s_d.rdata = {16'h0, s_q.cv_pre[1]};
        ADDR_ADD0: s_d.rdata = {16'h0, s_q.add[0]};
        ADDR_ADD1: s_d.rdata = {16'h0, s_q.add[1]};
        ADDR_CHCTL: s_d.rdata = s_q.chctl;
        ADDR_STAT: s_d.rdata = {24'h0, s_q.fired, s_q.filt, s_q.pin, s_q.ref_lvl};
        ADDR_CAP0: s_d.rdata = {16'h0, s_q.cap[0]};
        ADDR_CAP1: s_d.rdata = {16'h0, s_q.cap[1]};
        default: s_d.rdata = 32'h0;
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  // =====================================================
  // Register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.cfg <= CFG_RST;
      s_q.chctl <= CHCTL_RST;
      s_q.cv_pre <= {VAL_RST, VAL_RST};
      s_q.cv_act <= {VAL_RST, VAL_RST};
      s_q.add <= {VAL_RST, VAL_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign chan0_reference_out_o = s_q.ref_lvl[0];
  assign chan1_reference_out_o = s_q.ref_lvl[1];
  assign chan0_output_pin_o = s_q.pin[0];
  assign chan1_output_pin_o = s_q.pin[1];
  assign chan0_capture_o = s_q.cap_p[0];
  assign chan1_capture_o = s_q.cap_p[1];
endmodule

// ==== verification/tmc_timer_channel_mode_control_asserts.sv ====
// Port-level assertions for the timer channel mode control block
`timescale 1ns/1ps
module tmc_asserts
  import tmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ext_trigger_filtered_i,
  input wire logic chan0_reference_out_o,
  input wire logic chan0_output_pin_o,
  input wire logic chan0_capture_o
);
  // =====================================================
  // Mirror of settings, updated when a write completes
  logic busy_q, en0_q, pol0_q;
  logic [AW-1:0] adr_q;
  logic [31:0] dat_q, cc_q;
  logic [2:0] ms0;
  logic [3:0] cc0;
  logic out0, clr0;
  assign ms0 = {cc_q[MS_TOP], cc_q[1:0]};
  assign cc0 = {cc_q[CTL_TOP], cc_q[6:4]};
  assign out0 = (ms0 == IO_OUT) && !busy_q;
  assign clr0 = cc_q[CLR_BIT] && ext_trigger_filtered_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {busy_q, en0_q, pol0_q, adr_q, dat_q, cc_q} <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        busy_q <= 1'b1;
        adr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dat_q <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        busy_q <= 1'b0;
        if (adr_q == ADDR_CFG) begin
          en0_q <= dat_q[CFG_EN];
          pol0_q <= dat_q[CFG_POL];
        end
        if (adr_q == ADDR_CHCTL) begin
          cc_q <= en0_q ? {dat_q[31], cc_q[30], dat_q[29:2], cc_q[1:0]} : dat_q;
        end
      end
    end
  end
  // =====================================================
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  AST_R_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");
  AST_CLR_LOW: assert property (out0 && clr0 |=> !chan0_reference_out_o)
    else $error("clear did not drop the reference");
  AST_FORCE_HIGH: assert property (out0 && cc0 == CC_HIGH && !clr0 |=> chan0_reference_out_o)
    else $error("forced high not held");
  AST_FORCE_LOW: assert property (out0 && cc0 == CC_LOW |=> !chan0_reference_out_o)
    else $error("forced low not held");
  AST_TIMING_HOLD: assert property (out0 && cc0 == CC_TIMING && !clr0 |=> $stable(chan0_reference_out_o))
    else $error("reference moved in timing mode");
  AST_PIN_POL: assert property (!busy_q |=> chan0_output_pin_o == ($past(chan0_reference_out_o) ^ $past(pol0_q)))
    else $error("pin does not follow reference and polarity");
  AST_CAP_PULSE: assert property (chan0_capture_o |=> !chan0_capture_o)
    else $error("capture pulse longer than one cycle");
  AST_RSV_NOCAP: assert property (!busy_q && ms0[2] |=> !chan0_capture_o)
    else $error("capture in reserved mode");
  cover property (chan0_capture_o);
  cover property ($rose(chan0_reference_out_o));
  cover property (out0 && clr0);
endmodule
bind tmc_timer_channel_mode_control tmc_asserts i_tmc_asserts (.*);

// ==== verification/tb_timer_channel_mode_control.sv ====
// Self-checking bench for the timer channel mode control block
`timescale 1ns/1ps
module tb_timer_channel_mode_control;
  import tmc_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] counter_value_i = '0;
  logic count_down_i = 1'b0, update_evt_i = 1'b0, trig_edge_i = 1'b0;
  logic internal_trigger_i = 1'b0, ext_trigger_filtered_i = 1'b0;
  logic chan0_in_i = 1'b0, chan1_in_i = 1'b0;
  logic chan0_reference_out_o, chan1_reference_out_o, chan0_output_pin_o;
  logic chan1_output_pin_o, chan0_capture_o, chan1_capture_o;
  int miscompares = 0, num_checks = 0, ncap = 0;

  tmc_timer_channel_mode_control i_tmc_timer_channel_mode_control (.*);

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ncap <= ncap + int'(chan0_capture_o === 1'b1) + int'(chan1_capture_o === 1'b1);
  end
  // =====================================================
  // Common tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tmo();
    $display("[FAIL] t=%0t wait limit reached", $time);
    miscompares++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic ref0_is(input logic want);
    chk(32'(chan0_reference_out_o), 32'(want));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) tmo();
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) tmo();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] cc(input logic [3:0] c);
    return {15'h0, c[3], 9'h0, c[2:0], 4'h0};
  endfunction
  task automatic ctl(input logic [31:0] v);
    wr(ADDR_CHCTL, v, RESP_OKAY);
    cyc(2);
  endtask
  task automatic upd_pulse();
    update_evt_i <= 1'b1;
    @(posedge clk_i);
    update_evt_i <= 1'b0;
    cyc(3);
  endtask
  // Counts edges from the trigger launch edge to the pin change
  task automatic trig_delay(input int want);
    logic p;
    int k;
    p = chan0_output_pin_o;
    trig_edge_i <= 1'b1;
    @(posedge clk_i);
    trig_edge_i <= 1'b0;
    for (k = 2; k < 12; k++) begin
      @(posedge clk_i);
      #1;
      if (chan0_output_pin_o !== p) break;
    end
    if (k == 12) tmo();
    chk(32'(k), 32'(want));
    @(posedge clk_i);
  endtask
  task automatic drv(input int src, input logic v);
    if (src == 0) chan0_in_i <= v;
    else if (src == 1) chan1_in_i <= v;
    else internal_trigger_i <= v;
  endtask
  task automatic edges(input int src, input int n, input int w, input int want);
    int c0;
    c0 = ncap;
    repeat (n) begin
      drv(src, 1'b1);
      cyc(w);
      drv(src, 1'b0);
      cyc(w);
    end
    cyc(12);
    chk(32'(ncap - c0), 32'(want));
  endtask
  task automatic cap_cfg(input logic [31:0] v);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    wr(ADDR_CHCTL, v, RESP_OKAY);
    wr(ADDR_CFG, 32'h3, RESP_OKAY);
  endtask
  // =====================================================
  // Scenarios
  task automatic t_regs();
    rd(ADDR_CHCTL, CHCTL_RST, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(ADDR_CHCTL, 32'hffff_ffff, RESP_OKAY);
    rd(ADDR_CHCTL, CHCTL_WMASK, RESP_OKAY);
    ctl(32'h0);
    $display("test regs done");
  endtask
  task automatic t_force();
    ctl(32'h0000_5050);
    ref0_is(1'b1);
    chk(32'(chan1_reference_out_o), 32'h1);
    wr(ADDR_CFG, 32'h10, RESP_OKAY);
    cyc(2);
    chk(32'(chan0_output_pin_o), 32'h0);
    chk(32'(chan1_output_pin_o), 32'h1);
    ctl(32'h0000_4040);
    ref0_is(1'b0);
    chk(32'(chan1_reference_out_o), 32'h0);
    chk(32'(chan0_output_pin_o), 32'h1);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    $display("test force done");
  endtask
  task automatic t_match();
    logic [3:0] code [5] = '{CC_SET, CC_TIMING, CC_TOG, CC_TOG, CC_CLR};
    logic lvl [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(ADDR_CV0, 32'h10, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      ctl(cc(code[i]));
      counter_value_i <= 16'h0010;
      @(posedge clk_i);
      counter_value_i <= 16'h0000;
      cyc(3);
      ref0_is(lvl[i]);
    end
    $display("test match done");
  endtask
  task automatic t_pwm();
    logic [15:0] pt [4] = '{16'h5, 16'h20, 16'h20, 16'h5};
    logic a;
    for (int m = 6; m < 8; m++) begin
      ctl(cc(4'(m)));
      for (int i = 0; i < 4; i++) begin
        counter_value_i <= pt[i];
        count_down_i <= (i > 1);
        cyc(3);
        a = (i > 1) ? !(pt[i] > 16'h10) : (pt[i] < 16'h10);
        ref0_is(a ^ (m == 7));
      end
    end
    $display("test pwm done");
  endtask
  task automatic t_clear();
    ctl(cc(CC_HIGH) | 32'h80);
    ext_trigger_filtered_i <= 1'b1;
    cyc(3);
    ref0_is(1'b0);
    ext_trigger_filtered_i <= 1'b0;
    cyc(3);
    ref0_is(1'b1);
    $display("test clear done");
  endtask
  task automatic t_trig();
    logic st;
    // Below the compare value so the forced match level differs
    counter_value_i <= 16'h5;
    count_down_i <= 1'b0;
    ctl(cc(CC_PWM0) | 32'h4);
    ref0_is(1'b1);
    trig_delay(FAST_DLY);
    upd_pulse();
    for (int i = 0; i < 4; i++) begin
      count_down_i <= i[0];
      ctl(cc(i < 2 ? CC_SPM0 : CC_SPM1));
      upd_pulse();
      st = (i < 2) ^ i[0];
      ref0_is(st);
      trig_delay(SLOW_DLY);
      ref0_is(!st);
      upd_pulse();
      ref0_is(st);
    end
    $display("test trigger done");
  endtask
  task automatic t_shadow();
    counter_value_i <= 16'h18;
    count_down_i <= 1'b0;
    ctl(cc(CC_PWM0) | 32'h8);
    ref0_is(1'b0);
    wr(ADDR_CV0, 32'h20, RESP_OKAY);
    cyc(3);
    ref0_is(1'b0);
    upd_pulse();
    ref0_is(1'b1);
    ctl(32'h0);
    $display("test shadow done");
  endtask
  task automatic t_cpwm();
    wr(ADDR_ADD0, 32'h30, RESP_OKAY);
    wr(ADDR_CFG, 32'h4, RESP_OKAY);
    ctl(cc(CC_PWM0));
    counter_value_i <= 16'h28;
    cyc(3);
    ref0_is(1'b0);
    counter_value_i <= 16'h38;
    cyc(3);
    ref0_is(1'b1);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    cyc(3);
    ref0_is(1'b0);
    ctl(32'h0);
    $display("test composite done");
  endtask
  task automatic t_lock();
    wr(ADDR_CFG, 32'h1, RESP_OKAY);
    wr(ADDR_CHCTL, 32'h1, RESP_OKAY);
    rd(ADDR_CHCTL, 32'h0, RESP_OKAY);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    wr(ADDR_CHCTL, 32'h1, RESP_OKAY);
    rd(ADDR_CHCTL, 32'h1, RESP_OKAY);
    $display("test lock done");
  endtask
  task automatic t_cap();
    for (int p = 0; p < 4; p++) begin
      cap_cfg(32'(p << 2) | 32'h1);
      edges(0, 8, 4, 8 >> p);
    end
    cap_cfg(32'h2);
    edges(1, 2, 4, 2);
    edges(0, 2, 4, 0);
    cap_cfg(32'h0201);
    edges(0, 2, 4, 4);
    cap_cfg(32'h0100);
    edges(1, 2, 4, 2);
    cap_cfg(32'h3);
    edges(2, 2, 4, 2);
    cap_cfg(32'h4000_0001);
    edges(0, 2, 4, 0);
    cap_cfg(32'h31);
    edges(0, 1, 3, 0);
    edges(0, 1, 12, 1);
    wr(ADDR_CFG, 32'h0, RESP_OKAY);
    $display("test capture done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(2);
    t_regs();
    t_force();
    t_match();
    t_pwm();
    t_clear();
    t_trig();
    t_shadow();
    t_cpwm();
    t_lock();
    t_cap();
    print_verdict();
  end
endmodule
